// File: rtl/regulator_power_control_pkg.sv
// Package: register address, field positions, reset value and timing for the regulator control register
package regulator_power_control_pkg;

    localparam logic [7:0] REG_ADDR = 8'h00C9;
    localparam logic [7:0] REG_RESET = 8'h0000;
    localparam int BIT_IN_DIS = 7;
    localparam int BIT_VBUS = 6;
    localparam int BIT_RSV5 = 5;
    localparam int BIT_IN_LP = 4;
    localparam int BIT_STOP_OFF = 3;
    localparam int BIT_RSV2 = 2;
    localparam int BIT_CORE_LP = 1;
    localparam int BIT_MPC_EN = 0;
    // Clocks held off after a slow-to-fast clock change while the EPROM settles
    localparam logic [4:0] SETTLE_CLOCKS = 5'h0014;

    typedef enum logic [1:0] {
        MEM_ON,
        MEM_GATED,
        MEM_SETTLE
    } mem_state_t;

    typedef struct packed {
        logic [7:0] ctrl;
        mem_state_t mstate;
        logic [4:0] settle_cnt;
        logic [7:0] rdata;
    } state_t;

    typedef struct packed {
        logic input_regulator_disable;
        logic input_regulator_low_power;
        logic core_regulator_low_power;
        logic core_regulator_stop_off;
        logic ext_reset_only;
        logic eprom_power_on;
        logic fetch_stall;
    } power_ctrl_t;

endpackage : regulator_power_control_pkg

// File: rtl/regulator_power_control_reg.sv
// Regulator and memory power control register with EPROM power sequencing
`timescale 1ns/1ps
module regulator_power_control_reg
    import regulator_power_control_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // System status
    input wire logic bus_power_present,
    input wire logic stop_mode,
    input wire logic prefetch_enable,
    input wire logic fetch_active,
    input wire logic clock_slow_to_fast,
    // Power controls
    output power_ctrl_t power_ctrl
);

    state_t cur_ff;
    state_t nxt_cur;
    power_ctrl_t nxt_pc;
    power_ctrl_t pc_ff;

    function automatic logic hit(input logic [7:0] a);
        hit = (a == REG_ADDR);
    endfunction : hit

    always_comb begin
        logic [7:0] view;
        logic saver;
        saver = cur_ff.ctrl[BIT_MPC_EN] && !prefetch_enable;
        nxt_cur = cur_ff;
        view = cur_ff.ctrl;
        view[BIT_VBUS] = bus_power_present;
        if (sfr_wr && hit(sfr_addr)) begin
            // Bit 6 storage is never used, so writes to it are dropped
            nxt_cur.ctrl = sfr_wdata;
            nxt_cur.ctrl[BIT_VBUS] = 1'b0;
        end
        if (sfr_rd && hit(sfr_addr)) begin
            nxt_cur.rdata = view;
        end else if (sfr_rd) begin
            nxt_cur.rdata = 8'h0000;
        end
        case (cur_ff.mstate)
            MEM_ON: begin
                if (saver && !fetch_active) begin
                    nxt_cur.mstate = MEM_GATED;
                end
            end
            MEM_GATED: begin
                if (!saver) begin
                    nxt_cur.mstate = MEM_ON;
                end else if (clock_slow_to_fast) begin
                    nxt_cur.mstate = MEM_SETTLE;
                    nxt_cur.settle_cnt = SETTLE_CLOCKS;
                end else if (fetch_active) begin
                    nxt_cur.mstate = MEM_ON;
                end
            end
            MEM_SETTLE: begin
                // Holding fetches keeps reads away from a half-powered array
                if (cur_ff.settle_cnt <= 5'h0001) begin
                    nxt_cur.mstate = MEM_ON;
                    nxt_cur.settle_cnt = 5'h0000;
                end else begin
                    nxt_cur.settle_cnt = cur_ff.settle_cnt - 5'h0001;
                end
            end
            default: begin
                nxt_cur.mstate = MEM_ON;
            end
        endcase
        nxt_pc.input_regulator_disable = nxt_cur.ctrl[BIT_IN_DIS];
        nxt_pc.input_regulator_low_power = nxt_cur.ctrl[BIT_IN_LP];
        nxt_pc.core_regulator_low_power = nxt_cur.ctrl[BIT_CORE_LP];
        nxt_pc.core_regulator_stop_off = nxt_cur.ctrl[BIT_STOP_OFF] && stop_mode;
        nxt_pc.ext_reset_only = nxt_cur.ctrl[BIT_STOP_OFF] && stop_mode;
        nxt_pc.eprom_power_on = (nxt_cur.mstate != MEM_GATED);
        nxt_pc.fetch_stall = (nxt_cur.mstate == MEM_SETTLE);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_ff <= '{ctrl: REG_RESET, mstate: MEM_ON, settle_cnt: 5'h0000, rdata: 8'h0000};
            pc_ff <= '{default: 1'b0, eprom_power_on: 1'b1};
        end else begin
            cur_ff <= nxt_cur;
            pc_ff <= nxt_pc;
        end
    end

    assign sfr_rdata = cur_ff.rdata;
    assign power_ctrl = pc_ff;

endmodule : regulator_power_control_reg

// File: tb/regulator_power_control_properties.sv
// Register checker
`timescale 1ns/1ps
module regulator_power_control_properties
    import regulator_power_control_pkg::*;
(
    input wire logic clk, arst_n, sfr_wr, sfr_rd, bus_power_present, stop_mode, prefetch_enable, fetch_active,
    input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
    input wire power_ctrl_t power_ctrl
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire power_ctrl_t p = power_ctrl;
    wire logic hit = sfr_addr == REG_ADDR;
    // Stall must drop on the cycle after its twentieth
    sequence settle_s;
        ##19 p.fetch_stall ##1 !p.fetch_stall;
    endsequence
    reg_off_a: assert property (sfr_wr && hit |=> p.input_regulator_disable == $past(sfr_wdata[7]))
        else $error("regulator disable");
    vbus_live_a: assert property (sfr_rd && hit |=> sfr_rdata[6] == $past(bus_power_present))
        else $error("bus power");
    unmapped_read_a: assert property (sfr_rd && !hit |=> sfr_rdata == 8'h00) else $error("unmapped");
    stop_run_a: assert property (!stop_mode |=> !p.core_regulator_stop_off) else $error("stop");
    pin_only_a: assert property ($rose(p.ext_reset_only) |-> $past(stop_mode)) else $error("pin");
    prefetch_on_a: assert property (prefetch_enable |=> p.eprom_power_on) else $error("prefetch");
    fetch_on_a: assert property (fetch_active |=> p.eprom_power_on) else $error("fetch");
    settle_len_a: assert property ($rose(p.fetch_stall) |-> settle_s) else $error("settle");
endmodule : regulator_power_control_properties
bind regulator_power_control_reg regulator_power_control_properties i_chk (.*);

// File: tb/regulator_power_control_reg_test.sv
// Register bench
`timescale 1ns/1ps
module regulator_power_control_reg_test;
    import regulator_power_control_pkg::*;
    logic clk = 0, arst_n = 0, sfr_wr = 0, sfr_rd = 0, bus_power_present = 0, stop_mode = 1;
    logic prefetch_enable = 0, fetch_active = 0, clock_slow_to_fast = 0;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, n = 0, d;
    power_ctrl_t power_ctrl;
    int error_cnt = 0, n_compared = 0;
    // Bus power level above the byte written
    // Reserved bits written as 0, and bit 1 never set while bit 7 is set
    logic [8:0] rows [4] = '{9'h191, 9'h04A, 9'h1D9, 9'h000};
    regulator_power_control_reg i_dut (.*);
    task chk(input logic [7:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h", $time, got);
        end
    endtask : chk
    task acc(input logic w, input logic [7:0] v);
        @(negedge clk) {sfr_wr, sfr_rd, sfr_wdata} = {w, !w, v};
        @(negedge clk) {sfr_wr, sfr_rd} = 2'h0;
    endtask : acc
    task results;
        if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    initial forever #12.5 clk = !clk;
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        results;
    end
    initial begin
        #50 chk(sfr_rdata | 8'(power_ctrl), 8'h02);
        arst_n = 1;
        foreach (rows[i]) begin
            {sfr_addr, bus_power_present, d} = {REG_ADDR, rows[i]};
            acc(1, d);
            acc(0, d);
            chk(sfr_rdata, {d[7], bus_power_present, d[5:0]});
            chk(8'(power_ctrl[6:1]), {2'h0, d[7], d[4], d[1], d[3], d[3], !d[0]});
        end
        {stop_mode, sfr_addr} = {1'b0, 8'hC8};
        acc(1, 8'hFF);
        acc(0, d);
        chk(sfr_rdata, 8'h00);
        {fetch_active, prefetch_enable, sfr_addr} = {2'h3, REG_ADDR};
        acc(1, 8'h01);
        acc(0, d);
        chk({sfr_rdata[6:0], power_ctrl.eprom_power_on}, 8'h03);
        {fetch_active, prefetch_enable} = 2'h0;
        repeat (3) @(negedge clk);
        clock_slow_to_fast = 1;
        @(negedge clk) clock_slow_to_fast = 0;
        repeat (24) begin
            n += 8'(power_ctrl.fetch_stall);
            @(negedge clk);
        end
        chk(n, 8'h14);
        results;
    end
endmodule : regulator_power_control_reg_test
